//--- hdl/spds_defines.svh
/*
 Constants for the shutdown power-down sequencer and its partner end.
 Assumes inclusion by bare name from both ends and the package.
*/
// Contract
// - Decode fmt3, opcode 110110, opf 010000000
// - Wait until bus and cache idle
// - Then send request to clock generator
// - Internal reset held exactly 19 clocks
// - Then stop clock and PLL, clock high
// - Power-down output rises with internal reset
// - Partner resets, stops clock, cache standby
// - External clock stops only after power-down
// - Inputs held at reset levels while down
// - Non-privileged execution traps, no sequence
// - Software saves state, shutdown issued last
`ifndef SPDS_DEFINES_SVH
`define SPDS_DEFINES_SVH
`define SPDS_FMT_HI 31
`define SPDS_FMT_LO 30
`define SPDS_FMT3 2'h2
`define SPDS_PRIMARY_OPCODE_FIELD_HI 24
`define SPDS_PRIMARY_OPCODE_FIELD_LO 19
`define SPDS_PRIMARY_OPCODE_FIELD_SHUTDOWN 6'h36
`define SPDS_OPF_HI 13
`define SPDS_OPF_LO 5
`define SPDS_OPF_SHUTDOWN 9'h080
`define SPDS_RESET_CLOCKS 5'h13
`define SPDS_CNT_W 5
`define SPDS_CNT_ONE 5'h01
`define SPDS_PARTNER_RESET_CLOCKS 5'h13
`endif

//--- hdl/spds_pkg.sv
/*
 Types shared by both ends of the sequencer.
 Assumes spds_defines.svh is on the include path.
*/
`include "spds_defines.svh"
package spds_pkg;
	typedef enum logic [2:0] {
		SPDS_RUN,
		SPDS_DRAIN,
		SPDS_REQ,
		SPDS_RESET,
		SPDS_STOPPED
	} spds_state_t;
	typedef enum logic [1:0] {
		SPDS_P_RUN,
		SPDS_P_RESET,
		SPDS_P_STOPPED
	} spds_pstate_t;
endpackage

//--- hdl/spds_link_if.sv
/*
 Link between the processor's sequencer and the data-buffer and cache partner.
 Assumes both ends share clk; the testbench instantiates it.
*/
`timescale 1ns/1ns
interface spds_link_if;
	logic external_power_down_out;
	modport device (output external_power_down_out);
	modport partner (input external_power_down_out);
endinterface

//--- hdl/spds_sequencer.sv
/*
 Processor end: decodes the shutdown instruction, drains outstanding traffic,
 then runs the clock generator's reset and clock-stop sequence.
 Assumes the pipeline presents one instruction per issue strobe and reports
 bus and cache activity as same-clock levels.
*/
`timescale 1ns/1ns
`include "spds_defines.svh"
module spds_sequencer (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Instruction issue
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic privileged,
	// Outstanding traffic
	input wire logic sysbus_busy,
	input wire logic ecache_busy,
	// Pipeline status
	output logic priv_trap,
	output logic shutdown_busy,
	// Clock generator view
	output logic clkgen_req,
	output logic internal_reset,
	output logic core_clk_gate_high,
	output logic pll_stop,
	// Link to partner
	spds_link_if.device link
);
	spds_pkg::spds_state_t state, next_state;
	logic [`SPDS_CNT_W-1:0] count, next_count;
	logic next_trap;
	logic is_shutdown;

	// Other register fields are ignored
	assign is_shutdown = issue_valid
		&& issue_instr[`SPDS_FMT_HI:`SPDS_FMT_LO] == `SPDS_FMT3
		&& issue_instr[`SPDS_PRIMARY_OPCODE_FIELD_HI:`SPDS_PRIMARY_OPCODE_FIELD_LO]
			== `SPDS_PRIMARY_OPCODE_FIELD_SHUTDOWN
		&& issue_instr[`SPDS_OPF_HI:`SPDS_OPF_LO] == `SPDS_OPF_SHUTDOWN;

	always_comb
	begin
		next_state = state;
		next_count = count;
		next_trap = 1'b0;
		unique case (state)
			spds_pkg::SPDS_RUN:
			begin
				if (is_shutdown && !privileged)
					next_trap = 1'b1;
				else if (is_shutdown)
					next_state = spds_pkg::SPDS_DRAIN;
			end
			spds_pkg::SPDS_DRAIN:
			begin
				if (!sysbus_busy && !ecache_busy)
					next_state = spds_pkg::SPDS_REQ;
			end
			spds_pkg::SPDS_REQ:
			begin
				next_state = spds_pkg::SPDS_RESET;
				next_count = `SPDS_CNT_ONE;
			end
			spds_pkg::SPDS_RESET:
			begin
				if (count == `SPDS_RESET_CLOCKS)
					next_state = spds_pkg::SPDS_STOPPED;
				else
					next_count = `SPDS_CNT_W'(count + `SPDS_CNT_ONE);
			end
			spds_pkg::SPDS_STOPPED:
				next_state = spds_pkg::SPDS_STOPPED;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= spds_pkg::SPDS_RUN;
			count <= '0;
			priv_trap <= 1'b0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			count <= next_count;
			priv_trap <= next_trap;
		end
	end

	assign shutdown_busy = state != spds_pkg::SPDS_RUN;
	assign clkgen_req = state == spds_pkg::SPDS_REQ;
	assign internal_reset = state == spds_pkg::SPDS_RESET;
	// Power-down output rises with internal reset and stays up
	assign link.external_power_down_out = internal_reset
		|| state == spds_pkg::SPDS_STOPPED;
	// Clock parked high, so the last core edge is a rising one
	assign core_clk_gate_high = state == spds_pkg::SPDS_STOPPED;
	assign pll_stop = state == spds_pkg::SPDS_STOPPED;
endmodule

//--- hdl/spds_partner.sv
/*
 Partner end: data-buffer chip and external cache reaction to power-down.
 Assumes the power-down level arrives over the link on the shared clock.
*/
`timescale 1ns/1ns
`include "spds_defines.svh"
module spds_partner (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Link from processor
	spds_link_if.partner link,
	// Partner status
	output logic data_buffer_chip_reset,
	output logic data_buffer_chip_clk_stop,
	output logic ecache_standby,
	output logic ext_clk_stop_ok
);
	spds_pkg::spds_pstate_t state, next_state;
	logic [`SPDS_CNT_W-1:0] count, next_count;

	always_comb
	begin
		next_state = state;
		next_count = count;
		unique case (state)
			spds_pkg::SPDS_P_RUN:
			begin
				if (link.external_power_down_out)
				begin
					next_state = spds_pkg::SPDS_P_RESET;
					next_count = `SPDS_CNT_ONE;
				end
			end
			spds_pkg::SPDS_P_RESET:
			begin
				if (count == `SPDS_PARTNER_RESET_CLOCKS)
					next_state = spds_pkg::SPDS_P_STOPPED;
				else
					next_count = `SPDS_CNT_W'(count + `SPDS_CNT_ONE);
			end
			spds_pkg::SPDS_P_STOPPED:
				next_state = spds_pkg::SPDS_P_STOPPED;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= spds_pkg::SPDS_P_RUN;
			count <= '0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	assign data_buffer_chip_reset = state == spds_pkg::SPDS_P_RESET;
	assign data_buffer_chip_clk_stop = state == spds_pkg::SPDS_P_STOPPED;
	assign ecache_standby = state != spds_pkg::SPDS_P_RUN;
	// Only after power-down seen and partner reset done
	assign ext_clk_stop_ok = data_buffer_chip_clk_stop;
endmodule

//--- verif/spds_link_asserts.sv
/* Assertions across both sequencer ends.
 Assumes one clock; sits beside the link. */
`timescale 1ns/1ns
module spds_link_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched signals
	input wire logic issue_valid,
	input wire logic privileged,
	input wire logic sysbus_busy,
	input wire logic ecache_busy,
	input wire logic priv_trap,
	input wire logic clkgen_req,
	input wire logic internal_reset,
	input wire logic pll_stop,
	input wire logic external_power_down_out,
	input wire logic data_buffer_chip_reset,
	input wire logic ext_clk_stop_ok
);
	// Counter, since 19 is beyond a short repetition
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	always_comb next_cnt = internal_reset ? 5'(cnt + 5'h01) : 5'h00;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt <= 5'h00;
		else
			cnt <= next_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	req_idle_a: assert property (clkgen_req |-> $past(!sysbus_busy && !ecache_busy))
		else $error("request while busy");
	req_reset_a: assert property (clkgen_req |=> $rose(internal_reset))
		else $error("no reset after request");
	reset_len_a: assert property ($fell(internal_reset) |-> cnt == 5'h13)
		else $error("reset length wrong");
	clk_stop_a: assert property ($fell(internal_reset) |-> pll_stop)
		else $error("clock not stopped");
	pd_with_reset_a: assert property ($rose(internal_reset) |-> $rose(external_power_down_out))
		else $error("power-down not with reset");
	pd_stays_a: assert property (external_power_down_out |=> external_power_down_out)
		else $error("power-down dropped");
	trap_cause_a: assert property (priv_trap |-> $past(issue_valid && !privileged))
		else $error("trap without cause");
	buf_reset_a: assert property ($rose(external_power_down_out) |=> data_buffer_chip_reset)
		else $error("buffer did not reset");
	stop_ok_a: assert property (ext_clk_stop_ok |-> external_power_down_out)
		else $error("clock stop before power-down");
	cover property (priv_trap);
	cover property (clkgen_req);
	cover property ($fell(internal_reset));
endmodule

//--- verif/test_shutdown_power_down_sequencer.sv
/* Bench joining both sequencer ends.
 Assumes design files and checker compiled first. */
`timescale 1ns/1ns
module test_shutdown_power_down_sequencer;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic issue_valid = 1'b0;
	logic [31:0] issue_instr = 32'h0;
	logic privileged = 1'b0;
	logic sysbus_busy = 1'b0;
	logic ecache_busy = 1'b0;
	logic clk_en = 1'b1;
	logic priv_trap, shutdown_busy, clkgen_req, internal_reset, core_clk_gate_high, pll_stop;
	logic data_buffer_chip_reset, data_buffer_chip_clk_stop, ecache_standby, ext_clk_stop_ok;
	logic pwr_down;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	int miss[7] = '{5, 12, 13, 19, 24, 30, 31};
	spds_link_if link ();
	assign pwr_down = link.external_power_down_out;
	spds_sequencer u_spds_sequencer (.clk, .rst_n, .clk_en, .issue_valid, .issue_instr,
		.privileged, .sysbus_busy, .ecache_busy, .priv_trap, .shutdown_busy, .clkgen_req,
		.internal_reset, .core_clk_gate_high, .pll_stop, .link);
	spds_partner u_spds_partner (.clk, .rst_n, .clk_en, .link, .data_buffer_chip_reset,
		.data_buffer_chip_clk_stop, .ecache_standby, .ext_clk_stop_ok);
	spds_link_asserts u_spds_link_asserts (.clk, .rst_n, .issue_valid, .privileged,
		.sysbus_busy, .ecache_busy, .priv_trap, .clkgen_req, .internal_reset, .pll_stop,
		.external_power_down_out(pwr_down), .data_buffer_chip_reset, .ext_clk_stop_ok);
	initial forever #10 clk = ~clk;
	task chk(input logic ok);
		total_checks++;
		if (ok !== 1'b1)
			$display("MISMATCH %0t wrong output", $time);
		if (ok !== 1'b1)
			num_errors++;
	endtask
	function logic [31:0] sd(input logic [31:0] r);
		return {2'h2, 5'h00, 6'h36, 5'h00, 9'h080, 5'h00} | (r & 32'h3E07C01F);
	endfunction
	// Random words must never decode as the shutdown by chance
	function logic [31:0] not_sd(input logic [31:0] w);
		if (w[31:30] == 2'h2 && w[24:19] == 6'h36 && w[13:5] == 9'h080)
			return w ^ 32'h20;
		return w;
	endfunction
	task issue(input logic [31:0] w, input logic p);
		@(posedge clk);
		issue_valid <= 1'b1;
		issue_instr <= w;
		privileged <= p;
	endtask
	task results;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			$display("MISMATCH %0t timeout", $time);
			num_errors++;
			results;
		end
	end
	initial
	begin
		void'($urandom(45));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (n = 0; n < 37; n++)
		begin
			issue(n < 30 ? not_sd($urandom) : sd(0) ^ (32'h1 << miss[n % 7]), 1'($urandom));
			#1 chk(priv_trap === 1'b0 && shutdown_busy === 1'b0);
		end
		issue(sd(0), 1'b0);
		issue(sd($urandom), 1'b0);
		#1 chk(priv_trap === 1'b1);
		@(posedge clk) issue_valid <= 1'b0;
		#1 chk(priv_trap === 1'b1 && shutdown_busy === 1'b0);
		issue(sd($urandom), 1'b1);
		{sysbus_busy, ecache_busy} <= 2'h3;
		repeat ($urandom_range(2, 9))
		begin
			@(posedge clk) {sysbus_busy, ecache_busy} <= 2'($urandom_range(1, 3));
			issue_valid <= 1'b0;
			#1 chk(shutdown_busy === 1'b1 && clkgen_req === 1'b0 && pwr_down === 1'b0);
		end
		@(posedge clk) {sysbus_busy, ecache_busy} <= 2'h0;
		// Frozen by the enable, so idle traffic must not yet advance the drain
		clk_en <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(shutdown_busy === 1'b1 && clkgen_req === 1'b0);
		clk_en <= 1'b1;
		for (n = 0; clkgen_req !== 1'b1 && n < 4; n++) @(posedge clk) #1;
		chk(n < 4);
		@(posedge clk) #1 chk(internal_reset === 1'b1 && pwr_down === 1'b1);
		for (n = 0; internal_reset === 1'b1 && n < 30; n++) @(posedge clk) #1;
		chk(n == 19 && pll_stop === 1'b1 && core_clk_gate_high === 1'b1);
		chk(data_buffer_chip_reset === 1'b1 && ecache_standby === 1'b1);
		chk(data_buffer_chip_clk_stop === 1'b0 && ext_clk_stop_ok === 1'b0);
		@(posedge clk) #1 chk(ext_clk_stop_ok === 1'b1 && data_buffer_chip_reset === 1'b0);
		chk(data_buffer_chip_clk_stop === 1'b1);
		repeat (20)
		begin
			issue(sd($urandom), 1'($urandom));
			#1 chk(pwr_down === 1'b1 && pll_stop === 1'b1 && priv_trap === 1'b0);
		end
		issue_valid <= 1'b0;
		privileged <= 1'b0;
		rst_n <= 1'b0;
		#1 chk(pwr_down === 1'b0 && shutdown_busy === 1'b0);
		results;
	end
endmodule
